// File: rtl/ftp_pkg.sv
// package for the fast timer pwm block: register map, fields, reset values
// and timing counts. assumes a 125 MHz aclk and 32-bit axi4-lite access.
package ftp_pkg;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_SYNTH_CTRL_STATUS = 8'h27;
   localparam logic [7:0] IDX_CMP_B             = 8'h2B;
   localparam logic [7:0] IDX_TOP               = 8'h2D;
   localparam logic [7:0] IDX_CMP_A             = 8'h2E;
   localparam logic [7:0] IDX_COUNT             = 8'h2F;
   localparam logic [7:0] IDX_CTRL              = 8'h30;
   localparam logic [7:0] IDX_TIMER_FLAG_REG    = 8'h38;
   localparam logic [7:0] IDX_IRQ_MASK          = 8'h39;
   // synth_ctrl_status fields
   localparam int B_HALF_RATE_SEL = 7;
   localparam int B_FAST_CLK_SEL  = 2;
   localparam int B_SYNTH_EN      = 1;
   localparam int B_SYNTH_LOCKED  = 0;
   // flag and mask fields (same positions in both registers)
   localparam int B_CMP_A = 6;
   localparam int B_CMP_B = 5;
   localparam int B_WRAP  = 2;
   // control register fields
   localparam int B_CLR_ON_MATCH_A = 7;
   localparam int B_PWM_A_EN       = 6;
   localparam int B_OUT_MODE_A     = 4;
   localparam int B_PWM_B_EN       = 3;
   localparam int B_OUT_MODE_B     = 1;
   localparam int B_TIMER_RUN      = 0;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [7:0] RST_TOP  = 8'hFF;
   // output modes
   localparam logic [1:0] MODE_OFF   = 2'b00;
   localparam logic [1:0] MODE_PAIR  = 2'b01;
   localparam logic [1:0] MODE_CLR   = 2'b10;
   localparam logic [1:0] MODE_SET   = 2'b11;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   // timing
   localparam int CLK_PERIOD_PS = 8000;
   localparam int LOCK_TIME_US  = 100;
   localparam int LOCK_CYCLES   = (LOCK_TIME_US * 1000000) / CLK_PERIOD_PS;
   localparam int FAST_DIV      = 2;  // 125 MHz / 2, nearest to 64 MHz
   localparam int HALF_DIV      = 4;  // half of the fast rate
endpackage : ftp_pkg

// File: rtl/ftp_timer.sv
// fast timer pwm generator with axi4-lite register access.
// assumes one clock (aclk); the fast peripheral clock is modelled as a
// tick enable derived from aclk, so no second clock domain exists.
`timescale 1ns/1ps
// How it works
// - compare matches set cmp_a_flag bit 6, cmp_b_flag bit 5; ack or w1c clears
// - compare irqs need global enable, own enable and own flag
// - with both pwm enables low, wrap_flag sets on counter overflow
// - with any pwm enable high, wrap_flag sets on top_value match
// - a clear from clear_on_match_a never sets wrap_flag
// - wrap_flag clears on ack or one cycle after w1c; zero writes ignored
// - wrap irq requested only the cycle after global, wrap enable and flag all high
// - half_rate_sel zero gives full fast rate, one halves it
// - reserved bits of status and flag registers read zero
// - fast_clk_sel picks fast peripheral ticks, else system clock ticks
// - fast_clk_sel write of one only accepted when synth_en already one
// - synth_en starts the synth; forced one when it clocks the system
// - synth_locked read-only, sets after about 100 us of enable
// - pwm counter counts zero to top_value then restarts at zero
// - each channel drives a true output, plus an inverted one in pair mode only; zero dead time
// - output modes off, pair, clear-on-match, set-on-match
// - pwm compare writes held, moved to active at top match
// - reads of a pending compare return the held value
// - compare at zero or top gives a static output level
// - pwm period is top_value plus one timer ticks
// - pwm_b_en enables channel b pwm; counter zero after top match
// - only counting onto a compare value makes a match
module ftp_timer
   import ftp_pkg::*;
#(
   parameter int LOCK_CYC = ftp_pkg::LOCK_CYCLES
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        global_irq_en,
   input  wire logic        synth_is_sys_clk,
   input  wire logic        ack_cmp_a,
   input  wire logic        ack_cmp_b,
   input  wire logic        ack_wrap,
   output logic             irq_cmp_a,
   output logic             irq_cmp_b,
   output logic             irq_wrap,
   output logic             out_a_pin,
   output logic             out_a_pin_oe,
   output logic             out_a_inv,
   output logic             out_a_inv_oe,
   output logic             out_b_pin,
   output logic             out_b_pin_oe,
   output logic             out_b_inv,
   output logic             out_b_inv_oe
);
   import ftp_pkg::*;

   typedef struct packed {
      logic        aw_held;
      logic        awready;
      logic        wready;
      logic [7:0]  aw_idx;
      logic        w_held;
      logic [7:0]  w_data;
      logic        w_lane0;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [7:0]  rdata;
      logic [1:0]  rresp;
      logic        clr_on_match_a;
      logic        pwm_a_en;
      logic [1:0]  out_mode_a;
      logic        pwm_b_en;
      logic [1:0]  out_mode_b;
      logic        run;
      logic        half_rate_sel;
      logic        fast_clk_sel;
      logic        synth_en;
      logic        locked;
      logic [31:0] lock_cnt;
      logic [2:0]  div;
      logic [7:0]  count;
      logic        counted;
      logic [7:0]  top;
      logic [7:0]  cmp_a_hold;
      logic [7:0]  cmp_a_act;
      logic [7:0]  cmp_b_hold;
      logic [7:0]  cmp_b_act;
      logic [2:0]  irq_en;   // {a, b, wrap}
      logic [2:0]  flags;    // {a, b, wrap}
      logic [2:0]  clr_pend; // {a, b, wrap}
      logic [2:0]  irq;
      logic [7:0]  pins;     // {a, a_oe, ai, ai_oe, b, b_oe, bi, bi_oe}
   } ftp_state_t;

   ftp_state_t st_q;
   ftp_state_t st_d;

   // pwm level of the true output for one channel
   function automatic logic pwm_level(input logic [1:0] mode,
                                      input logic [7:0] cnt,
                                      input logic [7:0] cmp,
                                      input logic [7:0] top);
      logic hi;
      hi = 1'b0;
      if (cmp == 8'h00) begin
         hi = 1'b0;
      end else if (cmp >= top) begin
         hi = 1'b1;
      end else begin
         hi = (cnt >= 8'h01) && (cnt < cmp);
      end
      pwm_level = (mode == MODE_SET) ? ~hi : hi;
   endfunction : pwm_level

   // true, true_oe, inverted, inverted_oe for one channel
   function automatic logic [3:0] pair_pins(input logic en,
                                            input logic [1:0] mode,
                                            input logic lvl);
      logic [3:0] p;
      p = 4'h0;
      if (en && mode != MODE_OFF) begin
         p[3] = lvl;
         p[2] = 1'b1;
         if (mode == MODE_PAIR) begin
            p[1] = ~lvl;
            p[0] = 1'b1;
         end
      end
      pair_pins = p;
   endfunction : pair_pins

   logic       wr_go;
   logic       rd_go;
   logic       tick;
   logic       pwm_mode;
   logic       eff_synth;
   logic [2:0] div_lim;
   logic [2:0] set_ev;
   logic       hit_top;
   logic       hit_a;
   logic       hit_b;
   logic       wr_count;
   logic [7:0] rd_val;
   logic       rd_ok;

   always_comb begin
      st_d      = st_q;
      pwm_mode  = st_q.pwm_a_en | st_q.pwm_b_en;
      eff_synth = st_q.synth_en | synth_is_sys_clk;
      wr_go     = st_q.aw_held && st_q.w_held && !st_q.bvalid;
      rd_go     = s_axi_arvalid && st_q.arready;
      wr_count  = wr_go && st_q.w_lane0 && st_q.aw_idx == IDX_COUNT;
      set_ev    = 3'b000;

      // timer tick source
      if (!st_q.fast_clk_sel) begin
         div_lim = 3'h1;
      end else if (st_q.half_rate_sel) begin
         div_lim = 3'(HALF_DIV);
      end else begin
         div_lim = 3'(FAST_DIV);
      end
      tick = st_q.run && (st_q.div >= div_lim - 3'h1);
      if (!st_q.run || tick) begin
         st_d.div = 3'h0;
      end else begin
         st_d.div = st_q.div + 3'h1;
      end

      // matches only count when the counter stepped onto the value
      hit_top = tick && st_q.counted && st_q.count == st_q.top;
      hit_a   = tick && st_q.counted && st_q.count == st_q.cmp_a_act;
      hit_b   = tick && st_q.counted && st_q.count == st_q.cmp_b_act;
      set_ev[2] = hit_a;
      set_ev[1] = hit_b;

      if (tick) begin
         st_d.counted = 1'b1;
         if (pwm_mode && hit_top) begin
            st_d.count = 8'h00;
            set_ev[0]  = 1'b1;
            st_d.cmp_a_act = st_q.cmp_a_hold;
            st_d.cmp_b_act = st_q.cmp_b_hold;
         end else if (!pwm_mode && st_q.clr_on_match_a && hit_a) begin
            st_d.count = 8'h00;
         end else begin
            st_d.count = st_q.count + 8'h01;
            set_ev[0]  = !pwm_mode && st_q.count == 8'hFF;
         end
      end

      // synth enable and lock
      if (!eff_synth) begin
         st_d.lock_cnt = 32'h0000_0000;
         st_d.locked   = 1'b0;
      end else if (st_q.lock_cnt >= 32'(LOCK_CYC - 1)) begin
         st_d.locked   = 1'b1;
      end else begin
         st_d.lock_cnt = st_q.lock_cnt + 32'h0000_0001;
      end
      if (!eff_synth) begin
         st_d.fast_clk_sel = 1'b0;
      end

      // flags: set beats the delayed clear and the ack
      st_d.flags = (st_q.flags & ~st_q.clr_pend
                    & ~{ack_cmp_a, ack_cmp_b, ack_wrap})
                   | set_ev;
      st_d.clr_pend = 3'b000;
      st_d.irq = st_q.flags & st_q.irq_en & {3{global_irq_en}};

      // axi write channels
      if (s_axi_awvalid && !st_q.aw_held) begin
         st_d.aw_held = 1'b1;
         st_d.aw_idx  = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && !st_q.w_held) begin
         st_d.w_held  = 1'b1;
         st_d.w_data  = s_axi_wdata[7:0];
         st_d.w_lane0 = s_axi_wstrb[0];
      end
      if (st_q.bvalid && s_axi_bready) begin
         st_d.bvalid = 1'b0;
      end
      if (wr_go) begin
         st_d.aw_held = 1'b0;
         st_d.w_held  = 1'b0;
         st_d.bvalid  = 1'b1;
         st_d.bresp   = RESP_OKAY;
         unique case (st_q.aw_idx)
            IDX_SYNTH_CTRL_STATUS: if (st_q.w_lane0) begin
               st_d.half_rate_sel = st_q.w_data[B_HALF_RATE_SEL];
               st_d.synth_en      = st_q.w_data[B_SYNTH_EN];
               st_d.fast_clk_sel  = st_q.w_data[B_FAST_CLK_SEL]
                                    & eff_synth;
            end
            IDX_CMP_A: if (st_q.w_lane0) begin
               st_d.cmp_a_hold = st_q.w_data;
               if (!pwm_mode) st_d.cmp_a_act = st_q.w_data;
            end
            IDX_CMP_B: if (st_q.w_lane0) begin
               st_d.cmp_b_hold = st_q.w_data;
               if (!pwm_mode) st_d.cmp_b_act = st_q.w_data;
            end
            IDX_TOP: if (st_q.w_lane0) st_d.top = st_q.w_data;
            IDX_COUNT: if (st_q.w_lane0) begin
               st_d.count   = st_q.w_data;
               st_d.counted = 1'b0;
            end
            IDX_CTRL: if (st_q.w_lane0) begin
               st_d.clr_on_match_a = st_q.w_data[B_CLR_ON_MATCH_A];
               st_d.pwm_a_en   = st_q.w_data[B_PWM_A_EN];
               st_d.out_mode_a = st_q.w_data[B_OUT_MODE_A +: 2];
               st_d.pwm_b_en   = st_q.w_data[B_PWM_B_EN];
               st_d.out_mode_b = st_q.w_data[B_OUT_MODE_B +: 2];
               st_d.run        = st_q.w_data[B_TIMER_RUN];
            end
            IDX_TIMER_FLAG_REG: if (st_q.w_lane0) begin
               // the clear lands one cycle later, as a sync stage would
               st_d.clr_pend = {st_q.w_data[B_CMP_A], st_q.w_data[B_CMP_B],
                                st_q.w_data[B_WRAP]};
            end
            IDX_IRQ_MASK: if (st_q.w_lane0) begin
               st_d.irq_en = {st_q.w_data[B_CMP_A], st_q.w_data[B_CMP_B],
                              st_q.w_data[B_WRAP]};
            end
            default: st_d.bresp = RESP_SLVERR;
         endcase
      end
      if (wr_count) begin
         st_d.count   = st_q.w_data;
      end

      // axi read
      rd_val = 8'h00;
      rd_ok  = 1'b1;
      unique case (s_axi_araddr[9:2])
         IDX_SYNTH_CTRL_STATUS: begin
            rd_val[B_HALF_RATE_SEL] = st_q.half_rate_sel;
            rd_val[B_FAST_CLK_SEL]  = st_q.fast_clk_sel;
            rd_val[B_SYNTH_EN]      = eff_synth;
            rd_val[B_SYNTH_LOCKED]  = st_q.locked;
         end
         IDX_CMP_A: rd_val = st_q.cmp_a_hold;
         IDX_CMP_B: rd_val = st_q.cmp_b_hold;
         IDX_TOP:   rd_val = st_q.top;
         IDX_COUNT: rd_val = st_q.count;
         IDX_CTRL:  rd_val = {st_q.clr_on_match_a, st_q.pwm_a_en,
                              st_q.out_mode_a, st_q.pwm_b_en,
                              st_q.out_mode_b, st_q.run};
         IDX_TIMER_FLAG_REG: begin
            rd_val[B_CMP_A] = st_q.flags[2];
            rd_val[B_CMP_B] = st_q.flags[1];
            rd_val[B_WRAP]  = st_q.flags[0];
         end
         IDX_IRQ_MASK: begin
            rd_val[B_CMP_A] = st_q.irq_en[2];
            rd_val[B_CMP_B] = st_q.irq_en[1];
            rd_val[B_WRAP]  = st_q.irq_en[0];
         end
         default: rd_ok = 1'b0;
      endcase
      if (rd_go) begin
         st_d.arready = 1'b0;
         st_d.rvalid  = 1'b1;
         st_d.rdata   = rd_val;
         st_d.rresp   = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (st_q.rvalid && s_axi_rready) begin
         st_d.rvalid  = 1'b0;
         st_d.arready = 1'b1;
      end

      // ready flags are registered copies so the ports come from flops
      st_d.awready = !st_d.aw_held;
      st_d.wready  = !st_d.w_held;

      // pins follow the registered counter state
      st_d.pins = {pair_pins(st_q.pwm_a_en, st_q.out_mode_a,
                             pwm_level(st_q.out_mode_a, st_q.count,
                                       st_q.cmp_a_act, st_q.top)),
                   pair_pins(st_q.pwm_b_en, st_q.out_mode_b,
                             pwm_level(st_q.out_mode_b, st_q.count,
                                       st_q.cmp_b_act, st_q.top))};
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q            <= '0;
         st_q.arready    <= 1'b1;
         st_q.awready    <= 1'b1;
         st_q.wready     <= 1'b1;
         st_q.top        <= RST_TOP;
         st_q.cmp_a_hold <= RST_BYTE;
         st_q.cmp_b_hold <= RST_BYTE;
      end else begin
         st_q <= st_d;
      end
   end

   assign s_axi_awready = st_q.awready;
   assign s_axi_wready  = st_q.wready;
   assign s_axi_bvalid  = st_q.bvalid;
   assign s_axi_bresp   = st_q.bresp;
   assign s_axi_arready = st_q.arready;
   assign s_axi_rvalid  = st_q.rvalid;
   assign s_axi_rdata   = {24'h00_0000, st_q.rdata};
   assign s_axi_rresp   = st_q.rresp;
   assign irq_cmp_a     = st_q.irq[2];
   assign irq_cmp_b     = st_q.irq[1];
   assign irq_wrap      = st_q.irq[0];
   assign out_a_pin     = st_q.pins[7];
   assign out_a_pin_oe  = st_q.pins[6];
   assign out_a_inv     = st_q.pins[5];
   assign out_a_inv_oe  = st_q.pins[4];
   assign out_b_pin     = st_q.pins[3];
   assign out_b_pin_oe  = st_q.pins[2];
   assign out_b_inv     = st_q.pins[1];
   assign out_b_inv_oe  = st_q.pins[0];
endmodule : ftp_timer

// File: sim/ftp_load.sv
// load on one pwm output pair, with a pull-down on each line.
// assumes pin levels and enables come straight from the timer.
`timescale 1ns/1ps
module ftp_load (
   input  wire logic pin,
   input  wire logic pin_oe,
   input  wire logic inv,
   input  wire logic inv_oe,
   output logic      line,
   output logic      line_n
);
   // a released line falls to the pull-down, never keeps a stale level
   assign line   = pin_oe & pin;
   assign line_n = inv_oe & inv;
endmodule : ftp_load

// File: sim/ftp_timer_props.sv
// checker for ftp_timer: bus answers, irq gating, pwm output pairs.
// assumes it is bound to ftp_timer and sees only that module's ports.
`timescale 1ns/1ps
module ftp_timer_props
   import ftp_pkg::*;
#(
   parameter int LOCK_CYC = 20
) (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        global_irq_en,
   input wire logic        irq_cmp_a,
   input wire logic        irq_cmp_b,
   input wire logic        irq_wrap,
   input wire logic        out_a_pin,
   input wire logic        out_a_pin_oe,
   input wire logic        out_a_inv,
   input wire logic        out_a_inv_oe,
   input wire logic        out_b_pin,
   input wire logic        out_b_pin_oe,
   input wire logic        out_b_inv,
   input wire logic        out_b_inv_oe
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
   sequence r_done; s_axi_rvalid && s_axi_rready; endsequence
   sequence b_done; s_axi_bvalid && s_axi_bready; endsequence
   a_read_answer: assert property (ar_taken |=> s_axi_rvalid)
      else $error("read address taken but no data next cycle");
   a_read_once: assert property (r_done |=> !s_axi_rvalid)
      else $error("read data repeated after handshake");
   a_write_once: assert property (b_done |=> !s_axi_bvalid)
      else $error("write response repeated after handshake");
   a_resp_code: assert property (s_axi_bvalid |->
      s_axi_bresp == RESP_OKAY || s_axi_bresp == RESP_SLVERR)
      else $error("write response code outside okay or slverr");
   a_high_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("read data upper bits not zero");
   a_irq_gate_a: assert property (irq_cmp_a |-> $past(global_irq_en))
      else $error("compare a irq without global enable");
   a_irq_gate_b: assert property (irq_cmp_b |-> $past(global_irq_en))
      else $error("compare b irq without global enable");
   a_irq_gate_w: assert property (irq_wrap |-> $past(global_irq_en))
      else $error("wrap irq without global enable");
   a_pair_a: assert property (out_a_pin_oe && out_a_inv_oe |-> out_a_inv != out_a_pin)
      else $error("channel a pair not complementary");
   a_pair_b: assert property (out_b_pin_oe && out_b_inv_oe |-> out_b_inv != out_b_pin)
      else $error("channel b pair not complementary");
   a_inv_needs_true: assert property ((!out_a_inv_oe || out_a_pin_oe) &&
      (!out_b_inv_oe || out_b_pin_oe))
      else $error("inverted output driven without true output");
   a_idle_low: assert property (!out_a_pin_oe |-> !out_a_pin)
      else $error("released output a not low");
endmodule : ftp_timer_props
bind ftp_timer ftp_timer_props #(.LOCK_CYC(LOCK_CYC)) ftp_timer_props_inst (.*);

// File: sim/ftp_timer_tb.sv
// self-checking bench for ftp_timer: registers, flags, irqs, pwm timing.
// assumes ftp_pkg is compiled first and a pull-down load on the pins.
`timescale 1ns/1ps
module ftp_timer_tb;
   import ftp_pkg::*;
   logic        aclk = 0, aresetn = 0;
   logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, seed = 32'h0000_0053;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, global_irq_en = 0;
   logic synth_is_sys_clk = 0, ack_cmp_a = 0, ack_cmp_b = 0, ack_wrap = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, irq_cmp_a, irq_cmp_b, irq_wrap, la, la_n, lb;
   logic out_a_pin, out_a_pin_oe, out_a_inv, out_a_inv_oe;
   logic out_b_pin, out_b_pin_oe, out_b_inv, out_b_inv_oe;
   int   err_total = 0, tests_run = 0;
   always #4 aclk = ~aclk;
   ftp_timer #(.LOCK_CYC(20)) ftp_timer_inst (.*);
   ftp_load ld_a (.pin(out_a_pin), .pin_oe(out_a_pin_oe), .inv(out_a_inv),
                  .inv_oe(out_a_inv_oe), .line(la), .line_n(la_n));
   ftp_load ld_b (.pin(out_b_pin), .pin_oe(out_b_pin_oe), .inv(out_b_inv),
                  .inv_oe(out_b_inv_oe), .line(lb), .line_n());
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // static true level for a compare at zero (k 0) or at top (k 1)
   function automatic logic exp_lvl(input int m, input int k);
      return (m != 0) && ((k == 1) ^ (m == 3));
   endfunction : exp_lvl
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_total++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr  <= {2'b00, idx, 2'b00};
      s_axi_wdata   <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid && s_axi_bready) begin
            resp = s_axi_bresp;
            s_axi_bready <= 1'b0;
            break;
         end
      end
   endtask : wr
   task automatic rd(input logic [7:0] idx, output logic [31:0] d);
      @(posedge aclk);
      s_axi_araddr  <= {2'b00, idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      forever begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid && s_axi_rready) begin
            d = s_axi_rdata;
            resp = s_axi_rresp;
            s_axi_rready <= 1'b0;
            break;
         end
      end
   endtask : rd
   task automatic rdc(input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] d;
      rd(idx, d);
      chk(d, e);
   endtask : rdc
   // period and high time of one line, from one rising edge to the next
   task automatic per_hi(input logic b, output int p, output int h);
      logic pv = 1'b1;
      p = 0;
      h = 0;
      while (pv || !(b ? lb : la)) begin
         pv = b ? lb : la;
         @(posedge aclk);
      end
      do begin
         h += int'(b ? lb : la);
         p++;
         pv = b ? lb : la;
         @(posedge aclk);
      end while (pv || !(b ? lb : la));
   endtask : per_hi
   task automatic end_of_test();
      $display("tests_run %0d err_total %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : end_of_test
   // the whole run needs a few thousand cycles; this leaves wide margin
   initial begin
      repeat (40000) @(posedge aclk);
      err_total++;
      end_of_test();
   end
   initial begin
      logic [31:0] v;
      static logic [7:0] sel [3] = '{8'h02, 8'h06, 8'h86};
      static int         dv [3] = '{1, 2, 4};
      int          t, c, m, k, p, h;
      logic        hi, lo, e;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0000);
      rdc(IDX_TOP, {24'h00_0000, RST_TOP});
      rdc(8'h3F, 32'h0000_0000);
      chk(resp, RESP_SLVERR);
      wr(8'h3F, 8'h00);
      chk(resp, RESP_SLVERR);
      s_axi_wstrb <= 4'h0;
      wr(IDX_TOP, 8'h00);
      s_axi_wstrb <= 4'hF;
      rdc(IDX_TOP, {24'h00_0000, RST_TOP});
      synth_is_sys_clk <= 1'b1;
      rd(IDX_SYNTH_CTRL_STATUS, v);
      chk(v[B_SYNTH_EN], 1'b1);
      synth_is_sys_clk <= 1'b0;
      wr(IDX_SYNTH_CTRL_STATUS, 8'h04);
      chk(resp, RESP_OKAY);
      rdc(IDX_SYNTH_CTRL_STATUS, 32'h0000_0000);
      wr(IDX_SYNTH_CTRL_STATUS, 8'h02);
      rdc(IDX_SYNTH_CTRL_STATUS, 32'h0000_0002);
      do rd(IDX_SYNTH_CTRL_STATUS, v); while (v[B_SYNTH_LOCKED] !== 1'b1);
      wr(IDX_SYNTH_CTRL_STATUS, 8'hFE);
      rdc(IDX_SYNTH_CTRL_STATUS, 32'h0000_0087);
      $display("test registers done");
      t = 4 + rnd() % 12;
      c = 2 + rnd() % (t - 2);
      wr(IDX_TOP, t[7:0]);
      wr(IDX_CMP_A, c[7:0]);
      wr(IDX_CMP_B, c[7:0]);
      for (m = 0; m < 3; m++) begin
         wr(IDX_CTRL, 8'h00);
         wr(IDX_SYNTH_CTRL_STATUS, sel[m]);
         wr(IDX_CTRL, 8'h5F);
         per_hi(1'b0, p, h);
         per_hi(1'b0, p, h);
         chk(p, (t + 1) * dv[m]);
         chk(h, (c - 1) * dv[m]);
         per_hi(1'b1, p, h);
         chk(h, (t + 2 - c) * dv[m]);
         chk(out_b_inv_oe, 1'b0);
      end
      $display("test pwm timing done");
      wr(IDX_CTRL, 8'h00);
      wr(IDX_SYNTH_CTRL_STATUS, 8'h02);
      wr(IDX_CTRL, 8'h5F);
      c = 2 + rnd() % (t - 2);
      wr(IDX_CMP_A, c[7:0]);
      rdc(IDX_CMP_A, c);
      per_hi(1'b0, p, h);
      per_hi(1'b0, p, h);
      chk(h, c - 1);
      for (m = 0; m < 4; m++) begin
         for (k = 0; k < 2; k++) begin
            wr(IDX_CMP_A, k ? t[7:0] : 8'h00);
            wr(IDX_CTRL, 8'h41 | 8'(m << B_OUT_MODE_A));
            repeat (2 * t + 4) @(posedge aclk);
            hi = 1'b0;
            lo = 1'b1;
            repeat (t + 1) begin
               @(posedge aclk);
               hi |= la;
               lo &= la;
            end
            e = exp_lvl(m, k);
            chk({hi, lo}, {e, e});
            chk({out_a_pin_oe, out_a_inv_oe, la_n}, {m != 0, m == 1, m == 1 && !e});
         end
      end
      $display("test static levels done");
      wr(IDX_CTRL, 8'h5F);
      repeat (3 * t + 3) @(posedge aclk);
      wr(IDX_CTRL, 8'h00);
      wr(IDX_IRQ_MASK, 8'h64);
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0064);
      global_irq_en <= 1'b1;
      repeat (2) @(posedge aclk);
      chk({irq_cmp_a, irq_cmp_b, irq_wrap}, 3'b111);
      global_irq_en <= 1'b0;
      repeat (2) @(posedge aclk);
      chk({irq_cmp_a, irq_cmp_b, irq_wrap}, 3'b000);
      global_irq_en <= 1'b1;
      wr(IDX_TIMER_FLAG_REG, 8'h00);
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0064);
      wr(IDX_TIMER_FLAG_REG, 8'h04);
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0060);
      chk({irq_cmp_a, irq_wrap}, 2'b10);
      ack_cmp_a <= 1'b1;
      @(posedge aclk);
      ack_cmp_a <= 1'b0;
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0020);
      wr(IDX_TIMER_FLAG_REG, 8'hFF);
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0000);
      $display("test flags and irqs done");
      wr(IDX_TOP, 8'hFF);
      wr(IDX_CMP_A, 8'h0A);
      wr(IDX_CMP_B, 8'h0B);
      wr(IDX_COUNT, 8'h00);
      wr(IDX_CTRL, 8'h81);
      repeat (300) @(posedge aclk);
      wr(IDX_CTRL, 8'h00);
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0040);
      wr(IDX_TIMER_FLAG_REG, 8'hFF);
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0000);
      wr(IDX_CTRL, 8'h01);
      repeat (300) @(posedge aclk);
      wr(IDX_CTRL, 8'h00);
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0064);
      $display("test overflow done");
      wr(IDX_TIMER_FLAG_REG, 8'hFF);
      wr(IDX_COUNT, 8'h0A);
      wr(IDX_CTRL, 8'h01);
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0020);
      wr(IDX_CTRL, 8'h00);
      ack_cmp_b <= 1'b1;
      @(posedge aclk);
      ack_cmp_b <= 1'b0;
      rdc(IDX_TIMER_FLAG_REG, 32'h0000_0000);
      $display("test count write done");
      end_of_test();
   end
endmodule : ftp_timer_tb
